// [rtl/rfaci_pkg.sv]
// Constants and types of the roll feed axis control interface.
// Assumes a 125 MHz clock and a plain register port.
// Contract
// - Follow-up request held: position loop open, no control traversing.
// - Follow-up on stationary axis opens its loop at once.
// - Follow-up on moving axis: brake hard, wait delay, open loop.
// - Speed jog bit in manual jog: fixed speed, encoder ignored.
// - Jog method change takes effect only after keys are pressed again.
// - Sheet bit must be 1 for automatic traversing; else start refused.
// - Sheet bit falling during traversing puts both axes in follow-up.
// - Sheet bit rising ends follow-up; next start uses first block.
// - In set-up modes direction bit moves axis; at 0 no effect.
// - Rapid bit with direction command gives rapid speed, else config.
// - Enable closes loop; in speed jog it permits speed output.
// - Enable drop: zero command or quick stop, both axes follow-up.
// - Lift bit in manual jog ignores encoder and blocks keys.
// - Four mode bits decode to jog, increment, automatic, reference.
// - Ready flag high during cyclic exchange, low if absent or lost.
// - Effective feed length is total plus step size times steps.
// - Override of 100 percent uses programmed acceleration exactly.
package rfaci_pkg;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_NS = 8;
  localparam int SCAN_NS = 1000;
  localparam int SCAN_CYC = (SCAN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] WD_TICKS = 8'h14;
  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_AX1 = 5'h01;
  localparam logic [4:0] A_AX2 = 5'h02;
  localparam logic [4:0] A_STAT = 5'h03;
  localparam logic [4:0] A_IRQ_ST = 5'h04;
  localparam logic [4:0] A_IRQ_MK = 5'h05;
  localparam logic [4:0] A_DLY = 5'h06;
  localparam logic [4:0] A_SPD = 5'h07;
  localparam logic [4:0] A_RAP = 5'h08;
  localparam logic [4:0] A_STEP_SZ = 5'h09;
  localparam logic [4:0] A_STEP_N = 5'h0a;
  localparam logic [4:0] A_FEED = 5'h0b;
  localparam logic [4:0] A_FEED_EFF = 5'h0c;
  localparam logic [4:0] A_ACC = 5'h0d;
  localparam logic [4:0] A_ACC_CORR = 5'h0e;
  localparam logic [4:0] A_OVR = 5'h0f;
  localparam logic [4:0] A_ACC_EFF = 5'h10;
  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int C_SHEET = 0;
  localparam int C_JSPD = 1;
  localparam int C_FU = 2;
  localparam int C_START = 3;
  localparam int X_LIFT = 0;
  localparam int X_EN = 2;
  localparam int X_RAP = 5;
  localparam int X_MINUS = 6;
  localparam int X_PLUS = 7;
  localparam int I_FU1 = 0;
  localparam int I_REFUSE = 2;
  localparam int I_RDYLOST = 3;
  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] DLY_RST = 8'h0a;
  localparam logic [13:0] SPD_RST = 14'h0200;
  localparam logic [13:0] RAP_RST = 14'h1000;
  localparam logic [7:0] OVR_FULL = 8'h64;
  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    MD_NONE = 3'b000,
    MD_JOG = 3'b001,
    MD_INC = 3'b010,
    MD_AUTO = 3'b011,
    MD_REF = 3'b100
  } rfaci_mode_type;
  typedef enum logic [1:0] {
    AX_CLOSED = 2'b00,
    AX_BRAKE = 2'b01,
    AX_OPEN = 2'b10
  } rfaci_ax_type;
endpackage : rfaci_pkg

// [rtl/rfaci_top.sv]
// Roll feed axis control interface for two feed axes.
// Assumes synchronous inputs and a plain register port.
//
// The placing of the registers and the strobed register port are this design's own decisions.
module rfaci_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Axis feedback
  input wire logic [1:0] moving_i,
  input wire logic [1:0] done_i,
  // Feed module link
  input wire logic present_i,
  input wire logic beat_i,
  // Axis drive
  output logic [1:0] loop_closed_o,
  output logic [1:0] brake_o,
  output logic [1:0] enc_on_o,
  output logic [27:0] speed_cmd_o,
  // Status
  output logic ready_o,
  output logic irq_o
);
  typedef struct packed {
    logic [6:0] div;
    logic tick;
    logic [7:0] ctrl;
    logic [1:0][7:0] axc;
    logic [7:0] sc;
    logic [1:0][7:0] sa;
    rfaci_pkg::rfaci_mode_type mode;
    rfaci_pkg::rfaci_ax_type [1:0] ax;
    logic [1:0][7:0] cnt;
    logic [1:0] follow;
    logic [1:0] run;
    logic [1:0] key_act;
    logic [1:0] meth;
    logic [3:0] blk;
    logic first_blk;
    logic ready;
    logic [7:0] wd;
    logic [3:0] irq_st;
    logic [3:0] irq_mk;
    logic [7:0] dly;
    logic [13:0] spd;
    logic [13:0] rap;
    logic [15:0] step_sz;
    logic [7:0] step_n;
    logic [23:0] feed;
    logic [23:0] feed_eff;
    logic [15:0] acc;
    logic [15:0] acc_corr;
    logic [7:0] ovr;
    logic [15:0] acc_eff;
    logic [31:0] rdata;
    logic [1:0] loop_closed;
    logic [1:0] brake;
    logic [1:0] enc_on;
    logic [1:0][13:0] cmd;
    logic irq;
  } rfaci_state_type;

  rfaci_state_type q;
  rfaci_state_type s;

  // ***************************************************************
  // Mode decode
  // ***************************************************************
  function automatic rfaci_pkg::rfaci_mode_type rfaci_dec(
    input logic [3:0] m
  );
    case (m)
      4'h6: rfaci_dec = rfaci_pkg::MD_JOG;
      4'h7, 4'h5, 4'h4, 4'hc: rfaci_dec = rfaci_pkg::MD_INC;
      4'he, 4'ha: rfaci_dec = rfaci_pkg::MD_AUTO;
      4'hb, 4'h9, 4'h8: rfaci_dec = rfaci_pkg::MD_REF;
      default: rfaci_dec = rfaci_pkg::MD_NONE;
    endcase
  endfunction : rfaci_dec

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic [7:0] nc;
    logic [1:0][7:0] na;
    logic rise;
    logic fall;
    logic st_rise;
    logic req;
    logic setup;
    logic ok;
    logic [13:0] v;
    logic [3:0] ev;
    logic [3:0] clr;
    nc = q.ctrl;
    na = q.axc;
    rise = 1'b0;
    fall = 1'b0;
    st_rise = 1'b0;
    req = 1'b0;
    setup = 1'b0;
    ok = 1'b0;
    v = 14'h0000;
    ev = 4'h0;
    clr = 4'h0;
    s = q;
    s.tick = 1'b0;
    s.rdata = 32'h0000_0000;
    // Scan divider
    if (q.div == 7'(rfaci_pkg::SCAN_CYC - 1)) begin
      s.div = 7'h00;
      s.tick = 1'b1;
    end else begin
      s.div = q.div + 7'h01;
    end
    // Register writes
    if (wr_i) begin
      case (addr_i)
        rfaci_pkg::A_CTRL: s.ctrl = wdata_i[7:0];
        rfaci_pkg::A_AX1: s.axc[0] = wdata_i[7:0];
        rfaci_pkg::A_AX2: s.axc[1] = wdata_i[7:0];
        rfaci_pkg::A_IRQ_ST: clr = wdata_i[3:0];
        rfaci_pkg::A_IRQ_MK: s.irq_mk = wdata_i[3:0];
        rfaci_pkg::A_DLY: s.dly = wdata_i[7:0];
        rfaci_pkg::A_SPD: s.spd = wdata_i[13:0];
        rfaci_pkg::A_RAP: s.rap = wdata_i[13:0];
        rfaci_pkg::A_STEP_SZ: s.step_sz = wdata_i[15:0];
        rfaci_pkg::A_STEP_N: s.step_n = wdata_i[7:0];
        rfaci_pkg::A_FEED: s.feed = wdata_i[23:0];
        rfaci_pkg::A_ACC: s.acc = wdata_i[15:0];
        rfaci_pkg::A_ACC_CORR: s.acc_corr = wdata_i[15:0];
        rfaci_pkg::A_OVR: s.ovr = wdata_i[7:0];
        default: ;
      endcase
    end
    // Register reads, answered next cycle
    if (rd_i) begin
      case (addr_i)
        rfaci_pkg::A_CTRL: s.rdata = {24'h00_0000, q.ctrl};
        rfaci_pkg::A_AX1: s.rdata = {24'h00_0000, q.axc[0]};
        rfaci_pkg::A_AX2: s.rdata = {24'h00_0000, q.axc[1]};
        rfaci_pkg::A_STAT: s.rdata = {18'h0_0000, q.blk, q.mode,
          q.ready, q.loop_closed, q.follow, q.run};
        rfaci_pkg::A_IRQ_ST: s.rdata = {28'h000_0000, q.irq_st};
        rfaci_pkg::A_IRQ_MK: s.rdata = {28'h000_0000, q.irq_mk};
        rfaci_pkg::A_DLY: s.rdata = {24'h00_0000, q.dly};
        rfaci_pkg::A_SPD: s.rdata = {18'h0_0000, q.spd};
        rfaci_pkg::A_RAP: s.rdata = {18'h0_0000, q.rap};
        rfaci_pkg::A_STEP_SZ: s.rdata = {16'h0000, q.step_sz};
        rfaci_pkg::A_STEP_N: s.rdata = {24'h00_0000, q.step_n};
        rfaci_pkg::A_FEED: s.rdata = {8'h00, q.feed};
        rfaci_pkg::A_FEED_EFF: s.rdata = {8'h00, q.feed_eff};
        rfaci_pkg::A_ACC: s.rdata = {16'h0000, q.acc};
        rfaci_pkg::A_ACC_CORR: s.rdata = {16'h0000, q.acc_corr};
        rfaci_pkg::A_OVR: s.rdata = {24'h00_0000, q.ovr};
        rfaci_pkg::A_ACC_EFF: s.rdata = {16'h0000, q.acc_eff};
        default: s.rdata = 32'h0000_0000;
      endcase
    end
    // Correction arithmetic
    s.feed_eff = q.feed + 24'($signed({1'b0, q.step_sz}) *
      $signed(q.step_n));
    if (q.ovr == rfaci_pkg::OVR_FULL) begin
      s.acc_eff = q.acc;
    end else begin
      s.acc_eff = q.acc + q.acc_corr;
    end
    // Ready flag from cyclic exchange watchdog
    if (!present_i) begin
      s.ready = 1'b0;
      s.wd = 8'h00;
    end else if (beat_i) begin
      s.ready = 1'b1;
      s.wd = 8'h00;
    end else if (q.tick && q.ready) begin
      if (q.wd == rfaci_pkg::WD_TICKS - 8'h01) begin
        s.ready = 1'b0;
      end else begin
        s.wd = q.wd + 8'h01;
      end
    end
    ev[rfaci_pkg::I_RDYLOST] = q.ready & ~s.ready;
    // Scan processing
    if (q.tick) begin
      s.sc = nc;
      s.sa = na;
      s.mode = rfaci_dec(nc[7:4]);
      rise = nc[rfaci_pkg::C_SHEET] & ~q.sc[rfaci_pkg::C_SHEET];
      fall = ~nc[rfaci_pkg::C_SHEET] & q.sc[rfaci_pkg::C_SHEET];
      st_rise = nc[rfaci_pkg::C_START] & ~q.sc[rfaci_pkg::C_START];
      setup = (s.mode == rfaci_pkg::MD_JOG) ||
        (s.mode == rfaci_pkg::MD_INC) || (s.mode == rfaci_pkg::MD_REF);
      if (fall && ((|q.run) || (|q.key_act))) begin
        s.follow = 2'b11;
      end
      for (int a = 0; a < 2; a++) begin
        if (q.sa[a][rfaci_pkg::X_EN] && !na[a][rfaci_pkg::X_EN]) begin
          s.follow = 2'b11;
        end
      end
      if (rise) begin
        s.follow = 2'b00;
        s.first_blk = 1'b1;
      end
      for (int a = 0; a < 2; a++) begin
        req = nc[rfaci_pkg::C_FU] | s.follow[a];
        if (s.follow[a] && !q.follow[a]) begin
          ev[rfaci_pkg::I_FU1 + a] = 1'b1;
        end
        // Follow-up sequencing
        case (q.ax[a])
          rfaci_pkg::AX_CLOSED: begin
            if (req && moving_i[a]) begin
              s.ax[a] = rfaci_pkg::AX_BRAKE;
              s.cnt[a] = q.dly;
            end else if (req) begin
              s.ax[a] = rfaci_pkg::AX_OPEN;
            end
          end
          rfaci_pkg::AX_BRAKE: begin
            if (q.cnt[a] == 8'h00) begin
              s.ax[a] = rfaci_pkg::AX_OPEN;
            end else begin
              s.cnt[a] = q.cnt[a] - 8'h01;
            end
          end
          rfaci_pkg::AX_OPEN: begin
            if (!req) begin
              s.ax[a] = rfaci_pkg::AX_CLOSED;
            end
          end
          default: s.ax[a] = rfaci_pkg::AX_CLOSED;
        endcase
        // Key traversing and latched jog method
        ok = setup && !(s.mode == rfaci_pkg::MD_JOG &&
          na[a][rfaci_pkg::X_LIFT]);
        if (!(|na[a][7:6])) begin
          s.key_act[a] = 1'b0;
        end else if (!q.key_act[a] && ok) begin
          s.key_act[a] = 1'b1;
          s.meth[a] = nc[rfaci_pkg::C_JSPD] &&
            s.mode == rfaci_pkg::MD_JOG;
        end
        if (!ok || (!s.meth[a] && s.ax[a] != rfaci_pkg::AX_CLOSED)) begin
          s.key_act[a] = 1'b0;
        end
        // Automatic traversing
        if (done_i[a] || req) begin
          s.run[a] = 1'b0;
        end
        if (st_rise && s.mode == rfaci_pkg::MD_AUTO) begin
          if (nc[rfaci_pkg::C_SHEET] && !req &&
              na[a][rfaci_pkg::X_EN]) begin
            s.run[a] = 1'b1;
          end else begin
            ev[rfaci_pkg::I_REFUSE] = 1'b1;
          end
        end
        // Speed command
        v = na[a][rfaci_pkg::X_RAP] ? q.rap : q.spd;
        if (!na[a][rfaci_pkg::X_EN]) begin
          s.cmd[a] = 14'h0000;
        end else if (s.key_act[a] && na[a][rfaci_pkg::X_PLUS]) begin
          s.cmd[a] = v;
        end else if (s.key_act[a] && na[a][rfaci_pkg::X_MINUS]) begin
          s.cmd[a] = 14'h0000 - v;
        end else if (s.run[a]) begin
          s.cmd[a] = q.spd;
        end else begin
          s.cmd[a] = 14'h0000;
        end
        s.brake[a] = s.ax[a] == rfaci_pkg::AX_BRAKE;
        s.loop_closed[a] = s.ax[a] == rfaci_pkg::AX_CLOSED &&
          na[a][rfaci_pkg::X_EN] && !(s.key_act[a] && s.meth[a]);
        s.enc_on[a] = !(s.key_act[a] && s.meth[a]) &&
          !(s.mode == rfaci_pkg::MD_JOG && na[a][rfaci_pkg::X_LIFT]);
      end
      if (st_rise && (|s.run)) begin
        s.blk = q.first_blk ? 4'h0 : q.blk + 4'h1;
        s.first_blk = 1'b0;
      end
    end
    // Sticky events, set wins over clear
    s.irq_st = (q.irq_st & ~clr) | ev;
    s.irq = |(s.irq_st & s.irq_mk);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.dly <= rfaci_pkg::DLY_RST;
      q.spd <= rfaci_pkg::SPD_RST;
      q.rap <= rfaci_pkg::RAP_RST;
      q.ovr <= rfaci_pkg::OVR_FULL;
      q.first_blk <= 1'b1;
      q.enc_on <= 2'b11;
    end else begin
      q <= s;
    end
  end

  assign rdata_o = q.rdata;
  assign loop_closed_o = q.loop_closed;
  assign brake_o = q.brake;
  assign enc_on_o = q.enc_on;
  assign speed_cmd_o = q.cmd;
  assign ready_o = q.ready;
  assign irq_o = q.irq;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_fu_loop_open: assert property (
    q.ax[0] == rfaci_pkg::AX_OPEN |-> !loop_closed_o[0])
    else $error("Loop closed during follow-up");
  chk_fu_still_open: assert property (
    q.tick && q.ctrl[rfaci_pkg::C_FU] && !moving_i[0] &&
    q.ax[0] == rfaci_pkg::AX_CLOSED |=> q.ax[0] == rfaci_pkg::AX_OPEN)
    else $error("Stationary axis did not open");
  chk_fu_brake_out: assert property (
    q.tick && q.ctrl[rfaci_pkg::C_FU] && moving_i[1] &&
    q.ax[1] == rfaci_pkg::AX_CLOSED |=> brake_o[1] && !loop_closed_o[1])
    else $error("Moving axis not braked");
  chk_brake_end: assert property (
    q.tick && q.ax[1] == rfaci_pkg::AX_BRAKE && q.cnt[1] == 8'h00
    |=> q.ax[1] == rfaci_pkg::AX_OPEN)
    else $error("Brake delay did not end in open loop");
  chk_jog_enc_off: assert property (
    q.key_act[0] && q.meth[0] |-> !enc_on_o[0])
    else $error("Encoder used in speed jog");
  chk_lift_blocks: assert property (
    q.mode == rfaci_pkg::MD_JOG && q.sa[0][rfaci_pkg::X_LIFT]
    |-> !q.key_act[0])
    else $error("Keys active on lifted axis");
  chk_dir_idle: assert property (
    !(|q.sa[0][7:6])
    |-> !q.key_act[0])
    else $error("Key traversing without direction bit");
  chk_en_off_cmd: assert property (
    !q.sa[0][rfaci_pkg::X_EN]
    |-> speed_cmd_o[13:0] == 14'h0000 && !loop_closed_o[0])
    else $error("Output active without enable");
  chk_fu_no_run: assert property (
    q.tick && q.ctrl[rfaci_pkg::C_FU]
    |=> !q.run[0])
    else $error("Traversing during follow-up request");
  chk_ready_lost: assert property (
    $fell(ready_o)
    |-> q.irq_st[rfaci_pkg::I_RDYLOST])
    else $error("Ready loss not flagged");
  chk_en_zero_cmd: assert property (
    $fell(q.sa[0][rfaci_pkg::X_EN]) |->
    speed_cmd_o[13:0] == 14'h0000 && q.follow == 2'b11)
    else $error("Enable drop not handled");
  chk_sheet_refuse: assert property (
    q.tick && !q.ctrl[rfaci_pkg::C_SHEET] && !q.run[0] |=> !q.run[0])
    else $error("Start without sheet bit");
  chk_sheet_rise_end: assert property (
    q.tick && q.ctrl[rfaci_pkg::C_SHEET] && !q.sc[rfaci_pkg::C_SHEET]
    |=> q.follow == 2'b00 && q.first_blk)
    else $error("Rising sheet did not end follow-up");
  chk_mode_jog_dec: assert property (
    q.tick && q.ctrl[7:4] == 4'h6 |=> q.mode == rfaci_pkg::MD_JOG)
    else $error("Jog mode misdecoded");
  chk_ready_absent: assert property (
    !present_i |=> !ready_o)
    else $error("Ready without module");
  chk_feed_sum: assert property (
    $stable(q.feed) && $stable(q.step_sz) && $stable(q.step_n) |->
    q.feed_eff == q.feed + 24'($signed({1'b0, q.step_sz}) *
    $signed(q.step_n)))
    else $error("Feed correction wrong");
endmodule : rfaci_top

// [sim/rfaci_axis_model.sv]
// Far-side model: axis motion feedback and feed module heartbeat.
// Assumes the bench commands motion and loss of the heartbeat.
module rfaci_axis_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Bench control
  input wire logic [1:0] move_i,
  input wire logic beat_en_i,
  input wire logic [1:0] loop_closed_i,
  // Link to design
  output logic [1:0] moving_o,
  output logic [1:0] done_o,
  output logic present_o,
  output logic beat_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] cnt_q = 6'h00;
  always @(posedge sys_clk_i) begin
    cnt_q <= sys_rst_i ? 6'h00 : cnt_q + 6'h01;
    // Heartbeat every 64 clocks while the link is healthy
    beat_o <= !sys_rst_i && beat_en_i && (cnt_q == 6'h3f);
    moving_o <= move_i;
    // Traverse finished once a closed axis stands still
    done_o <= loop_closed_i & ~move_i;
    present_o <= !sys_rst_i;
  end
endmodule : rfaci_axis_model

// [sim/tb_rfaci_top.sv]
// Self-checking bench of the roll feed axis control interface.
// Assumes the axis model on the link and register access by tasks.
module tb_rfaci_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] moving, done, loop_closed, brake, enc_on;
  logic [1:0] move = 2'b00;
  logic present, beat, ready, irq;
  logic beat_en = 1'b1;
  logic [27:0] speed_cmd;
  int n_errors = 0;
  int n_checks = 0;
  always #4 sys_clk = ~sys_clk;

  rfaci_top rfaci_top_i (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .moving_i(moving), .done_i(done), .present_i(present), .beat_i(beat),
    .loop_closed_o(loop_closed), .brake_o(brake), .enc_on_o(enc_on),
    .speed_cmd_o(speed_cmd), .ready_o(ready), .irq_o(irq));
  rfaci_axis_model rfaci_axis_model_i (.sys_clk_i(sys_clk),
    .sys_rst_i(sys_rst), .move_i(move), .beat_en_i(beat_en),
    .loop_closed_i(loop_closed), .moving_o(moving), .done_o(done),
    .present_o(present), .beat_o(beat));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk_reg(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, e);
  endtask : chk_reg
  // Outputs follow the scan tick, every 125 clocks
  task automatic tick(input int n);
    repeat (n * 125 + 5) @(posedge sys_clk);
  endtask : tick
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
    chk(32'(enc_on), 32'h0000_0003);
    chk_reg(rfaci_pkg::A_DLY, 32'(rfaci_pkg::DLY_RST));
    chk_reg(rfaci_pkg::A_SPD, 32'(rfaci_pkg::SPD_RST));
    chk_reg(rfaci_pkg::A_RAP, 32'(rfaci_pkg::RAP_RST));
    chk_reg(rfaci_pkg::A_OVR, 32'(rfaci_pkg::OVR_FULL));
    chk_reg(5'h1f, 32'h0000_0000);
    for (int i = 0; i < 400 && ready !== 1'b1; i++) @(posedge sys_clk);
    if (ready !== 1'b1) begin
      n_errors++;
      report_and_stop;
    end
    chk(32'(ready), 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    logic [3:0] code [12] = '{4'h6, 4'h7, 4'h5, 4'h4, 4'hc, 4'he, 4'ha,
      4'hb, 4'h9, 4'h8, 4'h0, 4'hf};
    logic [2:0] md [12] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
      3'h4, 3'h4, 3'h4, 3'h0, 3'h0};
    logic [31:0] d;
    for (int i = 0; i < 12; i++) begin
      wr_reg(rfaci_pkg::A_CTRL, {24'h00_0000, code[i], 4'h0});
      tick(1);
      rd_reg(rfaci_pkg::A_STAT, d);
      chk(32'(d[9:7]), 32'(md[i]));
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_jog;
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_0062);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0084);
    tick(1);
    chk(32'(speed_cmd[13:0]), 32'(rfaci_pkg::SPD_RST));
    chk(32'(enc_on[0]), 32'h0000_0000);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_00a4);
    tick(1);
    chk(32'(speed_cmd[13:0]), 32'(rfaci_pkg::RAP_RST));
    // Method switched while the key stays pressed
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_0060);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0084);
    tick(1);
    chk(32'(enc_on[0]), 32'h0000_0000);
    chk(32'(speed_cmd[13:0]), 32'(rfaci_pkg::SPD_RST));
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0004);
    tick(1);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0084);
    tick(1);
    chk(32'(enc_on[0]), 32'h0000_0001);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0085);
    tick(1);
    chk(32'(enc_on[0]), 32'h0000_0000);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0004);
    tick(1);
    chk(32'(enc_on[0]), 32'h0000_0001);
    $display("test jog done");
  endtask : t_jog
  task automatic t_follow;
    wr_reg(rfaci_pkg::A_AX2, 32'h0000_0004);
    wr_reg(rfaci_pkg::A_DLY, 32'h0000_0002);
    wr_reg(rfaci_pkg::A_IRQ_MK, 32'h0000_0003);
    tick(1);
    chk(32'(loop_closed), 32'h0000_0003);
    @(posedge sys_clk);
    move <= 2'b10;
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_0064);
    tick(1);
    chk(32'(loop_closed[0]), 32'h0000_0000);
    chk(32'(brake[1]), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    tick(4);
    chk(32'(loop_closed), 32'h0000_0000);
    chk(32'(brake), 32'h0000_0000);
    wr_reg(rfaci_pkg::A_IRQ_MK, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0000_0000);
    move <= 2'b00;
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_0060);
    tick(1);
    chk(32'(loop_closed), 32'h0000_0003);
    wr_reg(rfaci_pkg::A_IRQ_ST, 32'h0000_0003);
    chk_reg(rfaci_pkg::A_IRQ_ST, 32'h0000_0000);
    $display("test follow done");
  endtask : t_follow
  task automatic t_sheet;
    logic [31:0] d;
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0000);
    tick(1);
    chk(32'(loop_closed), 32'h0000_0000);
    chk(32'(speed_cmd), 32'h0000_0000);
    rd_reg(rfaci_pkg::A_STAT, d);
    chk(32'(d[3:2]), 32'h0000_0003);
    chk_reg(rfaci_pkg::A_IRQ_ST, 32'h0000_0003);
    wr_reg(rfaci_pkg::A_AX1, 32'h0000_0004);
    wr_reg(rfaci_pkg::A_IRQ_ST, 32'h0000_000f);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e0);
    tick(1);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e8);
    tick(1);
    rd_reg(rfaci_pkg::A_IRQ_ST, d);
    chk(32'(d[rfaci_pkg::I_REFUSE]), 32'h0000_0001);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e1);
    tick(1);
    rd_reg(rfaci_pkg::A_STAT, d);
    chk(32'(d[3:2]), 32'h0000_0000);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e9);
    tick(1);
    rd_reg(rfaci_pkg::A_STAT, d);
    chk(32'(d[13:10]), 32'h0000_0000);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e1);
    tick(1);
    move <= 2'b11;
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e9);
    tick(1);
    rd_reg(rfaci_pkg::A_STAT, d);
    chk(32'(d[13:10]), 32'h0000_0001);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e8);
    tick(1);
    rd_reg(rfaci_pkg::A_STAT, d);
    chk(32'(d[3:2]), 32'h0000_0003);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e1);
    tick(1);
    wr_reg(rfaci_pkg::A_CTRL, 32'h0000_00e9);
    tick(1);
    rd_reg(rfaci_pkg::A_STAT, d);
    chk(32'(d[13:10]), 32'h0000_0000);
    @(posedge sys_clk);
    move <= 2'b00;
    $display("test sheet done");
  endtask : t_sheet
  task automatic t_calc;
    wr_reg(rfaci_pkg::A_STEP_SZ, 32'h0000_0005);
    wr_reg(rfaci_pkg::A_STEP_N, 32'h0000_00fd);
    wr_reg(rfaci_pkg::A_FEED, 32'h0000_03e8);
    wr_reg(rfaci_pkg::A_ACC, 32'h0000_0200);
    wr_reg(rfaci_pkg::A_ACC_CORR, 32'h0000_0010);
    tick(1);
    chk_reg(rfaci_pkg::A_FEED_EFF, 32'h0000_03d9);
    chk_reg(rfaci_pkg::A_ACC_EFF, 32'h0000_0200);
    wr_reg(rfaci_pkg::A_OVR, 32'h0000_0032);
    tick(1);
    chk_reg(rfaci_pkg::A_ACC_EFF, 32'h0000_0210);
    $display("test calc done");
  endtask : t_calc
  task automatic t_ready;
    @(posedge sys_clk);
    beat_en <= 1'b0;
    wr_reg(rfaci_pkg::A_IRQ_MK, 32'h0000_0008);
    tick(22);
    chk(32'(ready), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    $display("test ready done");
  endtask : t_ready

  // ***************************************************************
  // Main sequence and hang guard
  // ***************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_modes;
    t_jog;
    t_follow;
    t_sheet;
    t_calc;
    t_ready;
    report_and_stop;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    report_and_stop;
  end
endmodule : tb_rfaci_top
